// ---- bench/sac_host_model.sv ----
// Host model: drives converter clock, channel strobe, address, power down.
// Assumes a free-running system clock; all pin changes follow its edge.
module sac_host_model (
	// System clock
	input wire logic clock_i,
	// Converter pins
	output logic conv_clk_o,
	output logic wr_n_o,
	output logic channel_sel_hi_o,
	output logic channel_sel_lo_o,
	output logic power_down_in_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Shortest clock-low time, 150 ns at 20 ns a cycle
	localparam int LOW_MIN_CYC = 8;
	// Converter needs 13 cycles high to finish; one spare
	localparam int HIGH_CYC = 14;

	// Ladder levels are never moved, so no result needs discarding
	initial begin
		conv_clk_o = 1'b0;
		wr_n_o = 1'b1;
		channel_sel_hi_o = 1'b0;
		channel_sel_lo_o = 1'b0;
		power_down_in_o = 1'b0;
	end

	// Clock rests low between pulses so the converter tracks its input
	task automatic pulse(input int low_cyc);
		@(posedge clock_i);
		conv_clk_o <= 1'b1;
		repeat (HIGH_CYC) @(posedge clock_i);
		conv_clk_o <= 1'b0;
		repeat (low_cyc) @(posedge clock_i);
	endtask

	// Pins flip after the strobe rises: selection must not follow them
	task automatic select(input logic [1:0] ch);
		@(posedge clock_i);
		wr_n_o <= 1'b0;
		{channel_sel_hi_o, channel_sel_lo_o} <= ch;
		repeat (2) @(posedge clock_i);
		wr_n_o <= 1'b1;
		@(posedge clock_i);
		{channel_sel_hi_o, channel_sel_lo_o} <= ~ch;
	endtask

	task automatic set_pd(input logic v);
		@(posedge clock_i);
		power_down_in_o <= v;
	endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench: register access over Avalon-MM and conversions.
// Assumes the host model for converter pins and a 50 MHz clock.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock_i;
	logic arst_n;
	logic conv_clk, wr_n, sel_hi, sel_lo, pd;
	sac_pkg::sac_level_t [3:0] ain;
	sac_pkg::sac_level_t vref_hi, vref_lo;
	sac_pkg::sac_result_t result, saved;
	logic ladder_on, irq;
	logic [4:0] avs_address;
	logic avs_read, avs_write;
	logic [31:0] avs_writedata, avs_readdata, d, e;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest;
	int bad_count, checks_done, cycles;
	logic [11:0] lvl [8] = '{12'h080, 12'h100, 12'h101, 12'h300,
		12'h4fe, 12'h4ff, 12'h500, 12'h600};

	sac_host_model i_sac_host_model (.clock_i(clock_i),
		.conv_clk_o(conv_clk), .wr_n_o(wr_n), .channel_sel_hi_o(sel_hi),
		.channel_sel_lo_o(sel_lo), .power_down_in_o(pd));

	sac_adc_timing i_sac_adc_timing (.clock_i(clock_i), .arst_n_i(arst_n),
		.conv_clk_i(conv_clk), .wr_n_i(wr_n), .channel_sel_hi_i(sel_hi),
		.channel_sel_lo_i(sel_lo), .power_down_in_i(pd), .ain_i(ain),
		.vref_hi_i(vref_hi), .vref_lo_i(vref_lo), .result_o(result),
		.ladder_lo_connect_o(ladder_on), .irq_o(irq),
		.avs_address_i(avs_address), .avs_read_i(avs_read),
		.avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
		.avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest));

	initial clock_i = 1'b0;
	always #10 clock_i = ~clock_i;

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Whole run needs under a thousand cycles; ceiling leaves ample margin
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus_read(input logic [4:0] a, output logic [31:0] q);
		@(posedge clock_i);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
	endtask

	task automatic bus_write(input logic [4:0] a, input logic [31:0] v,
		input logic [3:0] be);
		@(posedge clock_i);
		avs_address <= a;
		avs_writedata <= v;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge clock_i); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	// Transfer curve from the reference pins, scaled to stay integer
	function automatic logic [31:0] exp_res(input int x);
		int span;
		int c;
		span = int'(vref_hi) - int'(vref_lo);
		x = x - int'(vref_lo);
		if (x < 0) return 32'h0;
		c = (2048 * x + span) / (2 * span);
		if (c >= 1024) return 32'h7ff;
		return 32'(c);
	endfunction

	// First pulse samples, second pulse moves its result to the outputs
	task automatic set_all(input logic [1:0] ch, input logic [11:0] v);
		for (int j = 0; j < 4; j++) begin
			ain[j] <= (j == int'(ch)) ? v : 12'h3c0;
		end
	endtask

	task automatic convert_twice;
		i_sac_host_model.pulse(i_sac_host_model.LOW_MIN_CYC);
		i_sac_host_model.pulse(10);
	endtask

	initial begin
		arst_n = 1'b0;
		ain = {4{12'h3c0}};
		vref_hi = 12'h500;
		vref_lo = 12'h100;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		repeat (16) @(posedge clock_i);
		arst_n <= 1'b1;
		@(posedge clock_i);
		bus_read(sac_pkg::CTRL_OFF, d);
		chk(d, 32'h1);
		bus_read(sac_pkg::IRQ_MASK_OFF, d);
		chk(d, 32'h0);
		bus_read(5'h14, d);
		chk(d, 32'h0);
		chk({31'h0, ladder_on}, 32'h1);
		bus_write(sac_pkg::CTRL_OFF, 32'h0, 4'h0);
		bus_read(sac_pkg::CTRL_OFF, d);
		chk(d, 32'h1);
		bus_write(sac_pkg::IRQ_MASK_OFF, 32'h3, 4'hf);
		for (int k = 0; k < 8; k++) begin
			i_sac_host_model.select(2'(k));
			set_all(2'(k), lvl[k]);
			convert_twice();
			e = exp_res(int'(lvl[k]));
			chk({21'h0, result}, e);
			bus_read(sac_pkg::RESULT_OFF, d);
			chk(d, e);
			chk({31'h0, irq}, 32'h1);
			bus_read(sac_pkg::IRQ_STATUS_OFF, d);
			chk(d, {30'h0, e[10], 1'b1});
			bus_read(sac_pkg::STATUS_OFF, d);
			chk(d, 32'h30 | (32'(k % 4) << 2));
			bus_write(sac_pkg::IRQ_STATUS_OFF, 32'h3, 4'hf);
			repeat (2) @(posedge clock_i);
			chk({31'h0, irq}, 32'h0);
		end
		// Power down: outputs frozen, lower reference opened
		saved = result;
		i_sac_host_model.set_pd(1'b1);
		repeat (3) @(posedge clock_i);
		chk({31'h0, ladder_on}, 32'h0);
		set_all(2'd3, 12'h200);
		convert_twice();
		chk({21'h0, result}, {21'h0, saved});
		i_sac_host_model.set_pd(1'b0);
		repeat (3) @(posedge clock_i);
		chk({31'h0, ladder_on}, 32'h1);
		convert_twice();
		chk({21'h0, result}, exp_res(32'h200));
		// Disabled converter starts no conversion on a pulse; masked load keeps irq low
		bus_write(sac_pkg::IRQ_MASK_OFF, 32'h0, 4'hf);
		bus_write(sac_pkg::CTRL_OFF, 32'h0, 4'hf);
		set_all(2'd3, 12'h400);
		convert_twice();
		chk({21'h0, result}, exp_res(32'h200));
		bus_write(sac_pkg::CTRL_OFF, 32'h1, 4'hf);
		convert_twice();
		convert_twice();
		chk({21'h0, result}, exp_res(32'h400));
		chk({31'h0, irq}, 32'h0);
		// Soft power down from the control register opens the reference
		bus_write(sac_pkg::CTRL_OFF, 32'h3, 4'hf);
		repeat (2) @(posedge clock_i);
		chk({31'h0, ladder_on}, 32'h0);
		bus_read(sac_pkg::STATUS_OFF, d);
		chk(d, 32'h2e);
		wrap_up();
	end
endmodule

// ---- rtl/sac_adc_timing.sv ----
// Conversion timing, channel select, output registers and register file.
// Assumes host pins are synchronous to clock_i and Avalon-MM software.
// Summary of operation
// R1: Track selected input while clock low; rising edge ends sampling.
// R2: Sample freezes a fixed aperture lag after the clock rising edge.
// R3: Coarse result picks sub-range; fine stage uses it while clock high.
// R4: Host discards one result when ladder levels move over one LSB.
// R5: Host may shorten a discarded sample's low time, never under 150 ns.
// R6: Overflow flags inputs from half LSB below top; data bits untouched.
// R7: Code is straight binary, 1024 times input offset over span.
// R8: First transition half LSB up, last 1.5 LSB below top reference.
// R9: Encoded result passes two cascaded flip-flops before the outputs.
// R10: Continuous or on-demand clocking; idle converter stays ready.
// R11: Each conversion completes within two clock periods of sampling.
// R12: Write strobe low lets address pins select; high keeps selection.
// R13: Power down holds data outputs and opens the lower reference.
// R14: Selection latched as the strobe rises, held until next write.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
module sac_adc_timing (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Converter pins from the host
	input wire logic conv_clk_i,
	input wire logic wr_n_i,
	input wire logic channel_sel_hi_i,
	input wire logic channel_sel_lo_i,
	input wire logic power_down_in_i,
	// Analog levels as numbers
	input wire sac_pkg::sac_level_t [3:0] ain_i,
	input wire sac_pkg::sac_level_t vref_hi_i,
	input wire sac_pkg::sac_level_t vref_lo_i,
	// Converter outputs
	output sac_pkg::sac_result_t result_o,
	output logic ladder_lo_connect_o,
	output logic irq_o,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	sac_pkg::sac_state_t state;
	logic conv_prev;
	logic conv_rise;
	logic [1:0] channel;
	logic [3:0] ap_cnt;
	sac_pkg::sac_level_t held;
	sac_pkg::sac_level_t offset;
	sac_pkg::sac_level_t span;
	logic sar_start;
	logic sar_done;
	sac_pkg::sac_result_t sar_result;
	sac_pkg::sac_result_t stage1;
	logic stage1_valid;
	logic [1:0] ctrl;
	logic pd_active;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [1:0] irq_event;
	logic out_load;
	logic wr_take;
	logic [31:0] next_readdata;

	assign conv_rise = conv_clk_i && !conv_prev;
	assign pd_active = power_down_in_i || ctrl[sac_pkg::CTRL_SOFT_PD_BIT];
	assign offset = (held >= vref_lo_i) ? held - vref_lo_i : 12'h000;
	assign span = (vref_hi_i > vref_lo_i) ? vref_hi_i - vref_lo_i : 12'h000;
	assign out_load = conv_rise && stage1_valid && !pd_active;
	assign wr_take = avs_write_i && !avs_waitrequest_o &&
		avs_byteenable_i[0];

	// Host pin edge detection
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			conv_prev <= 1'b0;
		else
			conv_prev <= conv_clk_i;
	end

	// Channel select follows the pins only while the strobe is low,
	// so the value present at the rising strobe edge stays latched
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			channel <= 2'h0;
		else if (!wr_n_i)
			channel <= {channel_sel_hi_i, channel_sel_lo_i}; // R12 R14
	end

	// Conversion sequencing
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= sac_pkg::SAC_TRACK;
			ap_cnt <= 4'h0;
			sar_start <= 1'b0;
		end else begin
			sar_start <= 1'b0;
			unique case (state)
				sac_pkg::SAC_TRACK: begin
					if (conv_rise && ctrl[sac_pkg::CTRL_ENABLE_BIT] &&
						!pd_active) begin
						state <= sac_pkg::SAC_APERTURE; // R1
						ap_cnt <= sac_pkg::APERTURE_CYC - 4'h1;
					end
				end
				sac_pkg::SAC_APERTURE: begin
					if (ap_cnt == 4'h0) begin
						state <= sac_pkg::SAC_CONVERT; // R2
						sar_start <= 1'b1;
					end else begin
						ap_cnt <= ap_cnt - 4'h1;
					end
				end
				sac_pkg::SAC_CONVERT: begin
					if (sar_done)
						state <= sac_pkg::SAC_BALANCED; // R11
				end
				sac_pkg::SAC_BALANCED: begin
					// Parks here until the host drops its clock; no
					// timer runs, so pulses may be far apart
					if (!conv_clk_i)
						state <= sac_pkg::SAC_TRACK; // R10
				end
			endcase
		end
	end

	// Sample tracks the selected input until the aperture lag runs out
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			held <= 12'h000;
		else if (state == sac_pkg::SAC_TRACK ||
			state == sac_pkg::SAC_APERTURE)
			held <= ain_i[channel]; // R1 R2
	end

	sac_sar u_sar (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.start_i(sar_start),
		.offset_i(offset),
		.span_i(span),
		.done_o(sar_done),
		.result_o(sar_result),
		.coarse_o()
	);

	// First output flop takes the encoded result; second one drives the
	// pins at the next host clock rise, as a pipeline would
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stage1 <= '0;
			stage1_valid <= 1'b0;
		end else begin
			if (out_load)
				stage1_valid <= 1'b0;
			if (sar_done) begin
				stage1 <= sar_result; // R9
				stage1_valid <= 1'b1;
			end
		end
	end

	// Data pins hold through power down
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			result_o <= '0;
		else if (out_load)
			result_o <= stage1; // R9 R13
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ladder_lo_connect_o <= 1'b0;
		else
			ladder_lo_connect_o <= !pd_active; // R13
	end

	// Control register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ctrl <= sac_pkg::CTRL_RESET;
		else if (wr_take && avs_address_i == sac_pkg::CTRL_OFF)
			ctrl <= avs_writedata_i[1:0];
	end

	// Interrupt status: hardware set wins over a write-one clear
	assign irq_event[sac_pkg::IRQ_READY_BIT] = out_load;
	assign irq_event[sac_pkg::IRQ_OVER_BIT] =
		out_load && stage1.overrange_flag;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_status <= 2'h0;
		else begin
			for (int i = 0; i < 2; i++) begin
				if (irq_event[i])
					irq_status[i] <= 1'b1;
				else if (wr_take &&
					avs_address_i == sac_pkg::IRQ_STATUS_OFF &&
					avs_writedata_i[i])
					irq_status[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_mask <= sac_pkg::IRQ_MASK_RESET;
		else if (wr_take && avs_address_i == sac_pkg::IRQ_MASK_OFF)
			irq_mask <= avs_writedata_i[1:0];
	end

	// Registered, so the line trails its status bit by one cycle
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status & irq_mask);
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (avs_address_i)
			sac_pkg::CTRL_OFF:
				next_readdata[1:0] = ctrl;
			sac_pkg::STATUS_OFF:
				next_readdata[5:0] = {stage1_valid, ladder_lo_connect_o,
					channel, pd_active, state != sac_pkg::SAC_TRACK};
			sac_pkg::RESULT_OFF:
				next_readdata[10:0] = result_o;
			sac_pkg::IRQ_STATUS_OFF:
				next_readdata[1:0] = irq_status;
			sac_pkg::IRQ_MASK_OFF:
				next_readdata[1:0] = irq_mask;
			default:
				next_readdata = 32'h0000_0000;
		endcase
	end

	// One wait cycle per access keeps read data off a combinational path
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_waitrequest_o) begin
			if (avs_read_i || avs_write_i) begin
				avs_waitrequest_o <= 1'b0;
				avs_readdata_o <= next_readdata;
			end
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	a_sample_tracks: assert property (@(posedge clock_i) // R1
		disable iff (!arst_n_i)
		state == sac_pkg::SAC_TRACK |=> held == $past(ain_i[channel]))
		else $error("Sample did not follow selected input");

	a_aperture_lag: assert property (@(posedge clock_i) // R2
		disable iff (!arst_n_i)
		state == sac_pkg::SAC_TRACK && conv_rise &&
		ctrl[sac_pkg::CTRL_ENABLE_BIT] && !pd_active
		|=> state == sac_pkg::SAC_APERTURE ##1
		state == sac_pkg::SAC_APERTURE ##1
		state == sac_pkg::SAC_CONVERT ##1 $stable(held))
		else $error("Sample not frozen after the aperture lag");

	a_overflow_apart: assert property (@(posedge clock_i) // R6
		disable iff (!arst_n_i)
		sar_done |=> stage1.code == $past(sar_result.code) &&
		stage1.overrange_flag == sac_pkg::sac_thresh_met($past(offset),
		$past(span), sac_pkg::OVER_INDEX))
		else $error("Overflow flag wrong or disturbed data");

	a_two_flops: assert property (@(posedge clock_i) // R9
		disable iff (!arst_n_i)
		out_load |=> result_o == $past(stage1) && !stage1_valid)
		else $error("Output did not take first flop contents");

	a_balanced_ready: assert property (@(posedge clock_i) // R10
		disable iff (!arst_n_i)
		state == sac_pkg::SAC_BALANCED && !conv_clk_i
		|=> state == sac_pkg::SAC_TRACK)
		else $error("Converter not ready to sample");

	a_convert_bound: assert property (@(posedge clock_i) // R11
		disable iff (!arst_n_i)
		$rose(state == sac_pkg::SAC_CONVERT)
		|-> ##[1:12] state == sac_pkg::SAC_BALANCED)
		else $error("Conversion overran its time");

	a_mux_hold: assert property (@(posedge clock_i) // R12
		disable iff (!arst_n_i)
		wr_n_i |=> $stable(channel))
		else $error("Selection changed while strobe high");

	a_mux_follow: assert property (@(posedge clock_i) // R14
		disable iff (!arst_n_i)
		!wr_n_i ##1 wr_n_i
		|-> channel == $past({channel_sel_hi_i, channel_sel_lo_i}))
		else $error("Selection not latched at strobe rise");

	a_pd_hold: assert property (@(posedge clock_i) // R13
		disable iff (!arst_n_i)
		pd_active |=> $stable(result_o) && !ladder_lo_connect_o)
		else $error("Power down did not hold outputs");
endmodule

// ---- rtl/sac_pkg.sv ----
// Shared constants and types for the subranging converter timing block.
// Assumes a 50 MHz system clock and numeric stand-ins for analog levels.
package sac_pkg;

	// Widths
	localparam int LEVEL_W = 12;
	localparam int CODE_W = 10;

	// Register byte offsets
	localparam logic [4:0] CTRL_OFF = 5'h00;
	localparam logic [4:0] STATUS_OFF = 5'h04;
	localparam logic [4:0] RESULT_OFF = 5'h08;
	localparam logic [4:0] IRQ_STATUS_OFF = 5'h0c;
	localparam logic [4:0] IRQ_MASK_OFF = 5'h10;

	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_SOFT_PD_BIT = 1;
	localparam int IRQ_READY_BIT = 0;
	localparam int IRQ_OVER_BIT = 1;

	// Reset values
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

	// Timing
	localparam int CLK_NS = 20;
	localparam int APERTURE_NS = 35;
	localparam logic [3:0] APERTURE_CYC =
		4'((APERTURE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] FINE_TOP_BIT = 4'h5;

	// Top transition index used for the overrange comparator
	localparam logic [10:0] OVER_INDEX = 11'h400;

	typedef logic [LEVEL_W-1:0] sac_level_t;

	typedef struct packed {
		logic overrange_flag;
		logic [CODE_W-1:0] code;
	} sac_result_t;

	typedef enum logic [1:0] {
		SAC_TRACK = 2'b00,
		SAC_APERTURE = 2'b01,
		SAC_CONVERT = 2'b10,
		SAC_BALANCED = 2'b11
	} sac_state_t;

	// True when offset x is at or above the transition into code c:
	// x >= span * (c - 0.5) / 1024, scaled by 2048 to stay integer.
	function automatic logic sac_thresh_met(input sac_level_t x,
		input sac_level_t span, input logic [10:0] c);
		logic [23:0] lhs;
		logic [23:0] rhs;
		lhs = 24'(x) << 11;
		rhs = 24'(span) * 24'({c, 1'b0} - 12'h001);
		return lhs >= rhs;
	endfunction

endpackage

// ---- rtl/sac_sar.sv ----
// Coarse then fine comparison engine, one comparison per clock.
// Assumes start_i pulses once with offset and span held steady.
module sac_sar (
	// Clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Request
	input wire logic start_i,
	input wire sac_pkg::sac_level_t offset_i,
	input wire sac_pkg::sac_level_t span_i,
	// Answer
	output logic done_o,
	output sac_pkg::sac_result_t result_o,
	output logic [3:0] coarse_o
);
	logic busy;
	logic [3:0] bit_idx;
	logic [9:0] code;
	logic [9:0] trial;
	sac_pkg::sac_level_t x;
	sac_pkg::sac_level_t span;

	assign trial = code | 10'(10'h001 << bit_idx);
	assign coarse_o = code[9:6];

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy <= 1'b0;
			bit_idx <= 4'h0;
			code <= 10'h000;
			x <= 12'h000;
			span <= 12'h000;
			done_o <= 1'b0;
			result_o <= '0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				busy <= 1'b1;
				bit_idx <= 4'h9;
				code <= 10'h000;
				x <= offset_i;
				span <= span_i;
			end else if (busy) begin
				// Upper four trials pick the sub-range, lower six refine in it
				if (sac_pkg::sac_thresh_met(x, span, {1'b0, trial}))
					code <= trial; // R3
				if (bit_idx == 4'h0) begin
					busy <= 1'b0;
					done_o <= 1'b1;
					result_o.code <= sac_pkg::sac_thresh_met(x, span,
						{1'b0, trial}) ? trial : code; // R7 R8
					result_o.overrange_flag <= sac_pkg::sac_thresh_met(x,
						span, sac_pkg::OVER_INDEX); // R6
				end else begin
					bit_idx <= bit_idx - 4'h1;
				end
			end
		end
	end

	a_fine_range_held: assert property (@(posedge clock_i) // R3
		disable iff (!arst_n_i)
		busy && !start_i && bit_idx <= sac_pkg::FINE_TOP_BIT
		|=> $stable(coarse_o))
		else $error("Sub-range moved during fine comparison");

	a_code_transitions: assert property (@(posedge clock_i) // R8
		disable iff (!arst_n_i)
		done_o |-> (result_o.code == 10'h000 ||
			sac_pkg::sac_thresh_met(x, span, {1'b0, result_o.code})) &&
			(result_o.code == 10'h3ff || !sac_pkg::sac_thresh_met(x, span,
			11'(result_o.code) + 11'h001)))
		else $error("Code not bounded by its transitions");
endmodule
